// >>> rtl/stgl_gain_limiter.sv
// The register offsets and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
// What this block does
// - fixed limiter voltage is max peak output times ten to threshold over 20.
// - fixed limiter passes below threshold; above, attenuation is threshold minus input.
// - fixed limiter caps output at its voltage; curve same for all high supplies.
// - fixed limiter threshold and knee stay referred to input full scale.
// - compressor knee field spans 0 to -15 dBFS; 0 dBFS disables compressor.
// - compressor voltage threshold is max peak output times ten to knee over 20.
// - compressor attenuation is target minus input times target over knee, above knee.
// - falling supply raises compression ratio; knee stays fixed to full scale.
// - combined mode needs knee below 0, fixed mode, threshold below 0.
// - combined mode applies no limiting when limiter voltage exceeds target peak and the knee is at or below the threshold.
// - begin pulse when attenuation first applied after being inactive.
// - end pulse when all attenuation released and block goes inactive.
// - no pulse while only adjusting the attenuation level.
// - maximum attenuation field spans -1 to -15 dB in 1 dB steps.
// - applied attenuation clamps at the selected maximum; beyond, signal passes.
// - distortion limiter threshold tracks target peak output continuously.
// - target is supply scaled by headroom; ratio above 0 dB is taken as 0 dB.
// - headroom field spans +20% to -20% in 2.5% steps.
// - fixed limiter threshold field spans 0 to -15 dBFS.
module stgl_gain_limiter
  import stgl_pkg::*;
#(
  parameter int SUP_W = 12,
  parameter int AW = 8,
  parameter logic [15:0] MPO_RST = 16'h0800,
  parameter logic [SUP_W-1:0] SUP_RST = '1
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic signed [DB_W-1:0] level_in,
  input wire logic level_valid,
  input wire logic [SUP_W-1:0] supply_code,
  input wire logic supply_valid,
  output logic signed [DB_W-1:0] atten_out,
  output logic atten_valid,
  output logic attenuation_begin_irq,
  output logic attenuation_end_irq
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // log2 in 1/64 octave, piecewise linear between powers of two
  function automatic logic [10:0] log2_q6(input logic [LOG_W-1:0] x);
    logic [4:0] p;
    logic [LOG_W-1:0] n;
    p = '0;
    for (int i = 0; i < LOG_W; i++) begin
      if (x[i]) begin
        p = 5'(i);
      end
    end
    n = x << (5'(LOG_W - 1) - p);
    return {p, n[LOG_W-2 -: DB_FRAC]};
  endfunction

  // byte-lane merge, the same for every writable word
  function automatic logic [31:0] merge_be(input logic [31:0] old_v, input logic [31:0] new_v,
                                          input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic [31:0] ctrl_r;
  logic [15:0] mpo_r;
  logic [SUP_W-1:0] supply_r;
  stgl_db_t target_peak_attenuation_r;
  stgl_db_t atten_r;
  logic active_r;
  logic [AW-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic aw_got_r;
  logic w_got_r;

  wire logic limiter_type_select = ctrl_r[CTRL_LIM_BIT];
  wire logic [SEL_W-1:0] compressor_knee_select = ctrl_r[CTRL_KNEE_LSB +: SEL_W];
  wire logic [SEL_W-1:0] fixed_limit_threshold = ctrl_r[CTRL_THR_LSB +: SEL_W];
  wire logic [SEL_W-1:0] max_attenuation_select = ctrl_r[CTRL_AMAX_LSB +: SEL_W];
  wire logic [HR_W-1:0] supply_headroom_select = ctrl_r[CTRL_HR_LSB +: HR_W];

  // ----------------------------------------------------------------
  // target peak attenuation
  // ----------------------------------------------------------------
  // headroom steps
  wire logic [HR_W-1:0] hr_code = (supply_headroom_select > HR_MAX) ? HR_MAX : supply_headroom_select;
  wire logic [LOG_W-1:0] tpo_num = LOG_W'(supply_r) * LOG_W'(HR_BASE - 6'(hr_code));
  wire logic [LOG_W-1:0] mpo_den = LOG_W'(mpo_r) * LOG_W'(HR_DEN);
  wire logic signed [12:0] oct_diff = $signed({2'b00, log2_q6(tpo_num)}) - $signed({2'b00, log2_q6(mpo_den)});
  wire logic signed [24:0] db_q8 = 25'(oct_diff) * 25'(DB_PER_OCT_Q8);
  wire logic signed [24:0] db_q = db_q8 >>> OCT_SHIFT;
  // never positive gain; a dead supply gives the deepest target
  wire stgl_db_t target_peak_attenuation_nxt = (tpo_num == '0 || db_q < 25'(DB_FLOOR)) ? DB_FLOOR :
                             (db_q > 25'(DB_ZERO)) ? DB_ZERO : DB_W'(db_q);

  // ----------------------------------------------------------------
  // per-function attenuation, all in 1/64 dB, zero or negative
  // ----------------------------------------------------------------
  // knee and threshold in dBFS, referred to input full scale
  wire stgl_db_t knee_db = -(DB_W'(compressor_knee_select) * DB_ONE);
  wire stgl_db_t thr_db = -(DB_W'(fixed_limit_threshold) * DB_ONE);
  // code 0 is read as the shallowest cap
  wire logic [SEL_W-1:0] amax_code = (max_attenuation_select == '0) ? AMAX_MIN : max_attenuation_select;
  wire stgl_db_t amax_db = -(DB_W'(amax_code) * DB_ONE);
  wire logic drc_on = compressor_knee_select != '0;
  // combined mode is the compressor plus the fixed limiter below 0 dBFS
  wire logic comb_mode = drc_on && limiter_type_select && fixed_limit_threshold != '0;

  // distortion limiter threshold is the target itself
  wire stgl_db_t sdl_att = (level_in > target_peak_attenuation_r) ? target_peak_attenuation_r - level_in : DB_ZERO;
  // fixed limiter; its voltage limit is the threshold in dB
  wire stgl_db_t sll_att = (level_in > thr_db) ? thr_db - level_in : DB_ZERO;
  wire stgl_db_t lim_att = limiter_type_select ? sll_att : sdl_att;

  // compressor slope; the knee divide is a reciprocal multiply
  wire logic signed [47:0] drc_prod = 48'(level_in) * 48'(target_peak_attenuation_r) * 48'(stgl_recip(compressor_knee_select));
  wire logic signed [47:0] drc_step = drc_prod >>> (RECIP_SHIFT + DB_FRAC);
  wire stgl_db_t drc_att = (drc_on && level_in > knee_db) ? target_peak_attenuation_r + DB_W'(drc_step) : DB_ZERO;

  // deepest attenuation wins; compress-then-limit reduces to the same min
  wire stgl_db_t pick_att = (drc_att < lim_att) ? drc_att : lim_att;
  // clamp, signal rises past this point
  wire stgl_db_t atten_nxt = (pick_att < amax_db) ? amax_db : pick_att;
  wire logic active_nxt = atten_nxt != DB_ZERO;

  // ----------------------------------------------------------------
  // datapath registers
  // ----------------------------------------------------------------
  // supply sampled on its strobe, target recomputed every cycle so the limits track the supply
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      supply_r <= SUP_RST;
      target_peak_attenuation_r <= DB_ZERO;
    end else begin
      if (supply_valid) begin
        supply_r <= supply_code;
      end
      target_peak_attenuation_r <= target_peak_attenuation_nxt;
    end
  end

  // one attenuation result per level sample; begin/end fire only on edges of activity
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      atten_r <= DB_ZERO;
      atten_valid <= 1'b0;
      active_r <= 1'b0;
      attenuation_begin_irq <= 1'b0;
      attenuation_end_irq <= 1'b0;
    end else begin
      atten_valid <= level_valid;
      attenuation_begin_irq <= level_valid && active_nxt && !active_r;
      attenuation_end_irq <= level_valid && !active_nxt && active_r;
      if (level_valid) begin
        atten_r <= atten_nxt;
        active_r <= active_nxt;
      end
    end
  end
  assign atten_out = atten_r;

  // ----------------------------------------------------------------
  // axi4-lite write side
  // ----------------------------------------------------------------
  wire logic wr_fire = aw_got_r && w_got_r && !s_axi_bvalid;
  wire logic wr_ctrl = awaddr_r == OFS_CTRL;
  wire logic wr_mpo = awaddr_r == OFS_MPO;
  wire logic wr_known = wr_ctrl || wr_mpo || awaddr_r == OFS_STATUS || awaddr_r == OFS_TPO;

  // address and data are taken in either order; ready drops until the response is taken
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_r <= s_axi_awaddr;
        aw_got_r <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
        w_got_r <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // writable words; status and target words ignore writes
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ctrl_r <= {11'h000, HR_RST, AMAX_RST, THR_RST, KNEE_RST, 4'h0};
      mpo_r <= MPO_RST;
    end else if (wr_fire && wr_ctrl) begin
      ctrl_r <= merge_be(ctrl_r, wdata_r, wstrb_r) & {11'h000, {HR_W{1'b1}}, 16'hFFF1};
    end else if (wr_fire && wr_mpo) begin
      mpo_r <= 16'(merge_be({16'h0000, mpo_r}, wdata_r, wstrb_r));
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite read side
  // ----------------------------------------------------------------
  // read mux decoded straight off the bus address; the answer register holds the word
  wire logic rd_known = s_axi_araddr == OFS_CTRL || s_axi_araddr == OFS_MPO ||
                        s_axi_araddr == OFS_STATUS || s_axi_araddr == OFS_TPO;
  wire logic [31:0] rd_word = (s_axi_araddr == OFS_CTRL) ? ctrl_r :
                              (s_axi_araddr == OFS_MPO) ? {16'h0000, mpo_r} :
                              (s_axi_araddr == OFS_STATUS) ? {atten_r, 15'h0000, active_r} :
                              (s_axi_araddr == OFS_TPO) ? {16'h0000, target_peak_attenuation_r} : 32'h0000_0000;

  // data answer one cycle after the address is taken
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_known ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  a_no_pos_gain: assert property (target_peak_attenuation_r <= DB_ZERO) else $error("target attenuation positive");
  a_atten_clamp: assert property (atten_valid |-> atten_r >= $past(amax_db) && atten_r <= DB_ZERO)
    else $error("attenuation beyond cap");
  a_sll_pass: assert property (level_valid && limiter_type_select && !drc_on && level_in <= thr_db
    |=> atten_r == DB_ZERO) else $error("fixed limiter touched low signal");
  a_sll_slope: assert property (level_valid && limiter_type_select && !drc_on && level_in > thr_db
    && thr_db - level_in >= amax_db |=> atten_r == $past(thr_db) - $past(level_in))
    else $error("fixed limiter slope wrong");
  a_sdl_track: assert property (level_valid && !limiter_type_select && !drc_on && level_in > target_peak_attenuation_r
    && target_peak_attenuation_r - level_in >= amax_db |=> atten_r == $past(target_peak_attenuation_r) - $past(level_in))
    else $error("distortion limiter off target");
  // combined mode with the limiter above target never deeper than the target
  a_comb_nolim: assert property (level_valid && comb_mode && thr_db > target_peak_attenuation_r && level_in <= DB_ZERO
    |=> atten_r >= $past(target_peak_attenuation_r)) else $error("limiter acted above target");
  a_begin_pulse: assert property ($rose(active_r) |-> attenuation_begin_irq ##1 !attenuation_begin_irq)
    else $error("missing begin pulse");
  a_end_pulse: assert property ($fell(active_r) |-> attenuation_end_irq && !attenuation_begin_irq)
    else $error("missing end pulse");
  a_irq_quiet: assert property (active_r && $past(active_r) |-> !attenuation_begin_irq && !attenuation_end_irq)
    else $error("pulse while adjusting");
  a_drc_below: assert property (level_valid && drc_on && limiter_type_select && fixed_limit_threshold == '0
    && level_in <= knee_db |=> atten_r == DB_ZERO) else $error("compressor touched low signal");
  a_cap_hold: assert property (level_valid && limiter_type_select && !drc_on && level_in > thr_db
    && thr_db - level_in < amax_db |=> atten_r == $past(amax_db)) else $error("attenuation not held at cap");
  a_begin_cause: assert property (attenuation_begin_irq |-> $rose(active_r))
    else $error("stray begin pulse");
  a_end_cause: assert property (attenuation_end_irq |-> $fell(active_r))
    else $error("stray end pulse");

  // bus answers: read data one cycle after the address, response one cycle after both halves
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  a_write_answer: assert property (wr_fire |=> s_axi_bvalid) else $error("write answer late");
  a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");

  // main scenarios reached
  c_begin_end: cover property (attenuation_begin_irq ##[1:200] attenuation_end_irq);
  c_drc_only: cover property (level_valid && drc_on && !comb_mode && drc_att < DB_ZERO);
  c_clamped: cover property (atten_valid && atten_r == amax_db);
  c_comb_mode: cover property (level_valid && comb_mode && sll_att < drc_att);
  c_ctrl_write: cover property (wr_fire && wr_ctrl);

endmodule

// >>> include/stgl_pkg.sv
package stgl_pkg;

  // ----------------------------------------------------------------
  // level units: signed, 1/64 dB steps
  // ----------------------------------------------------------------
  localparam int DB_W = 16;
  localparam int DB_FRAC = 6;
  localparam logic signed [DB_W-1:0] DB_ONE = 16'sh0040;
  localparam logic signed [DB_W-1:0] DB_ZERO = 16'sh0000;
  localparam logic signed [DB_W-1:0] DB_FLOOR = -16'sh2000;
  typedef logic signed [DB_W-1:0] stgl_db_t;

  // ----------------------------------------------------------------
  // register map, byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_MPO = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_TPO = 8'h0C;

  // control word fields
  localparam int CTRL_LIM_BIT = 0;
  localparam int CTRL_KNEE_LSB = 4;
  localparam int CTRL_THR_LSB = 8;
  localparam int CTRL_AMAX_LSB = 12;
  localparam int CTRL_HR_LSB = 16;
  localparam int SEL_W = 4;
  localparam int HR_W = 5;
  localparam int STAT_ATT_LSB = 16;

  // reset values: distortion limiter, compressor off, 0% headroom, -15 dB cap
  localparam logic [SEL_W-1:0] KNEE_RST = 4'h0;
  localparam logic [SEL_W-1:0] THR_RST = 4'h0;
  localparam logic [SEL_W-1:0] AMAX_RST = 4'hF;
  localparam logic [HR_W-1:0] HR_RST = 5'h08;
  localparam logic [HR_W-1:0] HR_MAX = 5'h10;
  localparam logic [SEL_W-1:0] AMAX_MIN = 4'h1;

  // ----------------------------------------------------------------
  // arithmetic constants
  // ----------------------------------------------------------------
  // target = supply * (HR_BASE - code) / HR_DEN, code 8 is 0 %, 2.5 % a step
  localparam logic [5:0] HR_BASE = 6'h30;
  localparam logic [5:0] HR_DEN = 6'h28;
  localparam int LOG_W = 24;
  // 20*log10(2) in 1/256 dB units per octave
  localparam logic signed [11:0] DB_PER_OCT_Q8 = 12'sh605;
  localparam int OCT_SHIFT = 8;
  localparam int RECIP_SHIFT = 12;
  localparam logic [12:0] RECIP_ONE = 13'h1000;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // reciprocal of a 1..15 dB knee, scaled by 2^RECIP_SHIFT
  function automatic logic [12:0] stgl_recip(input logic [SEL_W-1:0] k);
    logic [12:0] r;
    r = (k == '0) ? RECIP_ONE : 13'((RECIP_ONE + 13'(k >> 1)) / 13'(k));
    return r;
  endfunction

endpackage

// >>> verif/stgl_audio_src.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// playback level stream and supply converter stand-in
// ------------------------------------------------------------
module stgl_audio_src
  import stgl_pkg::*;
#(
  parameter int SUP_W = 12
) (
  input wire logic mclk,
  output stgl_db_t level_in,
  output logic level_valid,
  output logic [SUP_W-1:0] supply_code,
  output logic supply_valid
);
  // idle values at time zero
  initial begin
    level_in = DB_ZERO;
    level_valid = 1'b0;
    supply_code = '1;
    supply_valid = 1'b0;
  end
  // one-cycle sample strobe; the level bus shows garbage once released
  task automatic send_level(input stgl_db_t lvl);
    @(posedge mclk);
    level_in <= lvl;
    level_valid <= 1'b1;
    @(posedge mclk);
    level_in <= ~lvl;
    level_valid <= 1'b0;
  endtask
  // one conversion result; the code is only meaningful on its strobe
  task automatic set_supply(input logic [SUP_W-1:0] sup);
    @(posedge mclk);
    supply_code <= sup;
    supply_valid <= 1'b1;
    @(posedge mclk);
    supply_code <= ~sup;
    supply_valid <= 1'b0;
  endtask
endmodule

// >>> verif/supply_tracking_gain_limiter_bench.sv
`timescale 1ns/1ps
module supply_tracking_gain_limiter_bench
  import stgl_pkg::*;
;
  logic mclk, resetn;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  stgl_db_t level_in, atten_out, last_att;
  logic level_valid, supply_valid, atten_valid, attenuation_begin_irq, attenuation_end_irq;
  logic [11:0] supply_code;
  int errors = 0, samples_checked = 0, n_bgn = 0, n_end = 0, n_val = 0;
  stgl_gain_limiter dut (.mclk(mclk), .resetn(resetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .level_in(level_in), .level_valid(level_valid), .supply_code(supply_code), .supply_valid(supply_valid),
    .atten_out(atten_out), .atten_valid(atten_valid), .attenuation_begin_irq(attenuation_begin_irq),
    .attenuation_end_irq(attenuation_end_irq));
  stgl_audio_src src (.mclk(mclk), .level_in(level_in), .level_valid(level_valid), .supply_code(supply_code),
    .supply_valid(supply_valid));
  // ------------------------------------------------------------
  // clock, reset, watchdog
  // ------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // whole run is a few hundred cycles; 50k cycles means a hang
  initial begin
    #1000000;
    errors++;
    give_verdict();
  end
  // pulses stand a whole cycle, so the falling edge sees them settled
  always @(negedge mclk) begin
    if (atten_valid === 1'b1) begin
      last_att = atten_out;
      n_val++;
    end
    if (attenuation_begin_irq === 1'b1) n_bgn++;
    if (attenuation_end_irq === 1'b1) n_end++;
  end
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got, input int tol);
    int d;
    samples_checked++;
    d = $signed(got) - $signed(exp);
    if ((tol == 0 && got !== exp) || (tol != 0 && ((^got === 1'bx) || d > tol || d < -tol))) begin
      errors++;
      $display("BAD %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  // write: both channels offered together, each released when taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_hit, w_hit, b_hit;
    int n;
    n = 0;
    b_hit = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!b_hit && n < 100) begin
      @(negedge mclk);
      aw_hit = s_axi_awvalid && s_axi_awready;
      w_hit = s_axi_wvalid && s_axi_wready;
      b_hit = s_axi_bvalid && s_axi_bready;
      r = s_axi_bresp;
      @(posedge mclk);
      if (aw_hit) s_axi_awvalid <= 1'b0;
      if (w_hit) s_axi_wvalid <= 1'b0;
      n++;
    end
    chk("write answer", 32'h1, 32'(b_hit), 0);
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_hit, r_hit;
    int n;
    n = 0;
    r_hit = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!r_hit && n < 100) begin
      @(negedge mclk);
      ar_hit = s_axi_arvalid && s_axi_arready;
      r_hit = s_axi_rvalid && s_axi_rready;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge mclk);
      if (ar_hit) s_axi_arvalid <= 1'b0;
      n++;
    end
    chk("read answer", 32'h1, 32'(r_hit), 0);
  endtask
  task automatic cfg(input int lim, input int knee, input int thr, input int amax, input int hr);
    axi_wr(OFS_CTRL, 32'(lim | (knee << 4) | (thr << 8) | (amax << 12) | (hr << 16)), rs);
    chk("ctrl bresp", 32'(RESP_OKAY), 32'(rs), 0);
  endtask
  // one sample through, then attenuation and pulse counts compared
  task automatic samp(input int lvl, input int exp, input int tol, input int eb, input int ee);
    int b0, e0, v0;
    b0 = n_bgn;
    e0 = n_end;
    v0 = n_val;
    src.send_level(stgl_db_t'(lvl));
    repeat (3) @(posedge mclk);
    chk("result strobes", 32'h1, 32'(n_val - v0), 0);
    chk("atten_out", 32'(exp), 32'(last_att), tol);
    chk("begin pulses", 32'(eb), 32'(n_bgn - b0), 0);
    chk("end pulses", 32'(ee), 32'(n_end - e0), 0);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    resetn = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    repeat (10) @(posedge mclk);
    resetn <= 1'b1;
    // reset values, refused and read-only places
    axi_rd(OFS_CTRL, rd, rs);
    chk("ctrl reset", 32'h0008F000, rd, 0);
    axi_rd(OFS_MPO, rd, rs);
    chk("mpo reset", 32'h00000800, rd, 0);
    // reserved control bits read back as zero
    axi_wr(OFS_CTRL, 32'hFFFFFFFF, rs);
    axi_rd(OFS_CTRL, rd, rs);
    chk("ctrl mask", 32'h001FFFF1, rd, 0);
    // byte lanes: only the low byte of the word lands
    s_axi_wstrb <= 4'h1;
    axi_wr(OFS_MPO, 32'h000012AB, rs);
    s_axi_wstrb <= 4'hF;
    axi_rd(OFS_MPO, rd, rs);
    chk("mpo byte lane", 32'h000008AB, rd, 0);
    axi_wr(OFS_MPO, 32'h00000800, rs);
    axi_rd(8'h20, rd, rs);
    chk("unmapped rresp", 32'(RESP_SLVERR), 32'(rs), 0);
    axi_wr(8'h20, 32'hFFFFFFFF, rs);
    chk("unmapped bresp", 32'(RESP_SLVERR), 32'(rs), 0);
    axi_wr(OFS_TPO, 32'h0000FFFF, rs);
    chk("read-only bresp", 32'(RESP_OKAY), 32'(rs), 0);
    // full supply: fixed limiter at -6 dB, begin, adjust, end
    cfg(1, 0, 6, 15, 8);
    samp(-512, 0, 0, 0, 0);
    samp(-128, -256, 0, 1, 0);
    axi_rd(OFS_STATUS, rd, rs);
    chk("status word", 32'hFF000001, rd, 0);
    samp(0, -384, 0, 0, 0);
    samp(-448, 0, 0, 0, 1);
    // every fixed threshold code with a full-scale input
    for (int t = 0; t < 16; t++) begin
      cfg(1, 0, t, 15, 8);
      samp(0, -t * 64, 0, int'(t == 1), 0);
    end
    // clamp codes 1 to 15 against a -15 dB limit
    for (int m = 1; m < 16; m++) begin
      cfg(1, 0, 15, m, 8);
      samp(0, -m * 64, 0, 0, 0);
    end
    // half supply: target about -6.02 dB tracked by the distortion limiter
    src.set_supply(12'h400);
    cfg(0, 0, 0, 15, 8);
    axi_rd(OFS_TPO, rd, rs);
    chk("target atten", -32'sd385, 32'(stgl_db_t'(rd[15:0])), 32);
    samp(0, -385, 32, 0, 0);
    samp(-640, 0, 0, 0, 1);
    cfg(0, 0, 0, 3, 8);
    samp(0, -192, 0, 1, 0);
    // compressor only, knee at -6 dB
    cfg(1, 6, 0, 15, 8);
    samp(-128, -257, 32, 0, 0);
    samp(-512, 0, 0, 0, 1);
    cfg(1, 0, 0, 15, 8);
    samp(0, 0, 0, 0, 0);
    // combined, limiter above target: compressor alone acts
    cfg(1, 6, 2, 15, 8);
    samp(0, -385, 32, 1, 0);
    // supply back to full: no positive gain
    src.set_supply(12'hFFF);
    samp(0, -128, 0, 0, 0);
    cfg(0, 0, 0, 15, 8);
    samp(0, 0, 0, 0, 1);
    give_verdict();
  end
endmodule
